// >>> inc/opdec_regs.svh
// decoder constants: opcode patterns, field positions, mod and r/m field values
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH
`define MOD_HI 7
`define MOD_LO 6
`define SUB_HI 5
`define SUB_LO 3
`define MOD_REG 2'h3
`define MOD_D8 2'h1
`define MOD_D16 2'h2
`define MOD_NONE 2'h0
`define RM_DIRECT 3'h6
`define PFX_REP_Z 8'hF3
`define PFX_REP_NZ 8'hF2
`define PFX_LOCK 8'hF0
`define PFX_TWO_BYTE 8'h0F
`define OP_CLR_TS 8'h06
`define INT3_TYPE 8'h03
`endif

// >>> inc/opdec_pkg.sv
// decoder types: operation classes and the decoded result
package opdec_pkg;
    typedef enum logic [5:0] {
        OP_NONE = 6'h00, OP_ROTL = 6'h01, OP_ROTR = 6'h02, OP_RCL = 6'h03, OP_RCR = 6'h04,
        OP_SHL = 6'h05, OP_SHR = 6'h06, OP_SAR = 6'h07, OP_AND = 6'h08, OP_TEST = 6'h09,
        OP_OR = 6'h0A, OP_XOR = 6'h0B, OP_NOT = 6'h0C, OP_SMOVE = 6'h0D, OP_SCMP = 6'h0E,
        OP_SSCAN = 6'h0F, OP_SLOAD = 6'h10, OP_SSTORE = 6'h11, OP_SIN = 6'h12, OP_SOUT = 6'h13,
        OP_CALL = 6'h14, OP_CALLF = 6'h15, OP_JMP = 6'h16, OP_JMPF = 6'h17, OP_RET = 6'h18,
        OP_RETF = 6'h19, OP_JCC = 6'h1A, OP_LOOP = 6'h1B, OP_LOOPZ = 6'h1C, OP_LOOPNZ = 6'h1D,
        OP_JUMP_COUNT_ZERO = 6'h1E, OP_ENTER = 6'h1F, OP_LEAVE = 6'h20, OP_BOUND = 6'h21, OP_INT = 6'h22,
        OP_INTO = 6'h23, OP_CLC = 6'h24, OP_CMC = 6'h25, OP_STC = 6'h26, OP_HALT = 6'h27,
        OP_CLTS = 6'h28, OP_ESC = 6'h29, OP_OTHER = 6'h2A
    } op_class_t;
    typedef enum logic [1:0] {
        CNT_NONE = 2'h0, CNT_ONE = 2'h1, CNT_REG = 2'h2, CNT_IMM = 2'h3
    } count_src_t;
    typedef struct packed {
        op_class_t op;
        logic word;
        logic dir;
        logic [3:0] cond;
        count_src_t count_src;
        logic repeat_prefix;
        logic rep_z;
        logic lock;
        logic has_modrm;
        logic rm_is_reg;
        logic [1:0] modf;
        logic [2:0] regf;
        logic [2:0] rmf;
        logic [15:0] disp;
        logic [15:0] imm;
        logic [15:0] imm2;
        logic invalid;
    } decoded_t;
    typedef enum logic [2:0] {
        ST_OPC = 3'h0, ST_MODRM = 3'h1, ST_DISP = 3'h2, ST_IMM = 3'h3, ST_EXT = 3'h4
    } dec_state_t;
endpackage : opdec_pkg

// >>> hdl/opcode_decoder.sv
// opcode decoder for logic, string, control-transfer and processor-control groups
`timescale 1ns/1ps
`include "opdec_regs.svh"

module opcode_decoder
    import opdec_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // byte stream from fetch
    input wire logic [7:0] fetch_byte,
    input wire logic fetch_valid,
    output logic fetch_ready,
    // decoded instruction to execution
    output decoded_t dec_out,
    output logic dec_valid,
    output logic esc_valid
);
    dec_state_t state, next_state;
    decoded_t cur;
    logic [1:0] disp_left;
    logic [2:0] imm_left, imm_total;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // first-byte decode
    // ----------------------------------------
    wire logic [7:0] b = fetch_byte;
    wire logic w = b[0];
    wire logic take = fetch_valid && fetch_ready;
    wire logic [7:0] immw = w ? 8'h02 : 8'h01;
    wire logic is_shift = (b[7:1] == 7'h68) || (b[7:1] == 7'h69) || (b[7:1] == 7'h60);
    wire logic is_grp1 = (b[7:1] == 7'h40);
    wire logic is_grp3 = (b[7:1] == 7'h7B);
    wire logic is_ff = (b == 8'hFF);
    wire logic is_esc = (b[7:3] == 5'h1B);
    wire logic is_jcc = (b[7:4] == 4'h7);
    wire logic is_prefix = (b == `PFX_REP_Z) || (b == `PFX_REP_NZ) || (b == `PFX_LOCK);
    wire logic needs_modrm = is_shift || is_grp1 || is_grp3 || is_ff || is_esc
        || (b[7:2] == 6'h08) || (b[7:2] == 6'h02) || (b[7:2] == 6'h0C)
        || (b[7:1] == 7'h42) || (b == 8'h62);
    // immediate bytes for opcodes whose length is fixed by the first byte
    wire logic [2:0] fixed_imm =
        (b[7:1] == 7'h12 || b[7:1] == 7'h54 || b[7:1] == 7'h1A) ? immw[2:0] :
        (b == 8'hE8 || b == 8'hE9 || b == 8'hC2 || b == 8'hCA || b == 8'hC8) ? 3'h2 :
        (b == 8'h9A || b == 8'hEA) ? 3'h4 :
        (b == 8'hEB || is_jcc || b[7:2] == 6'h38 || b == 8'hCD) ? 3'h1 : 3'h0;

    op_class_t op1;
    always_comb begin
        case (b)
            8'hEB, 8'hE9: op1 = OP_JMP;
            8'hEA: op1 = OP_JMPF;
            8'hE8: op1 = OP_CALL;
            8'h9A: op1 = OP_CALLF;
            8'hC3, 8'hC2: op1 = OP_RET;
            8'hCB, 8'hCA: op1 = OP_RETF;
            8'hE2: op1 = OP_LOOP;
            8'hE1: op1 = OP_LOOPZ;
            8'hE0: op1 = OP_LOOPNZ;
            8'hE3: op1 = OP_JUMP_COUNT_ZERO;
            8'hC8: op1 = OP_ENTER;
            8'hC9: op1 = OP_LEAVE;
            8'h62: op1 = OP_BOUND;
            8'hCD, 8'hCC: op1 = OP_INT;
            8'hCE: op1 = OP_INTO;
            8'hF8: op1 = OP_CLC;
            8'hF5: op1 = OP_CMC;
            8'hF9: op1 = OP_STC;
            8'hF4: op1 = OP_HALT;
            8'hA4, 8'hA5: op1 = OP_SMOVE;
            8'hA6, 8'hA7: op1 = OP_SCMP;
            8'hAE, 8'hAF: op1 = OP_SSCAN;
            8'hAC, 8'hAD: op1 = OP_SLOAD;
            8'hAA, 8'hAB: op1 = OP_SSTORE;
            8'h6C, 8'h6D: op1 = OP_SIN;
            8'h6E, 8'h6F: op1 = OP_SOUT;
            8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25: op1 = OP_AND;
            8'h84, 8'h85, 8'hA8, 8'hA9: op1 = OP_TEST;
            8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D: op1 = OP_OR;
            8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35: op1 = OP_XOR;
            default: op1 = is_jcc ? OP_JCC : is_esc ? OP_ESC : OP_OTHER;
        endcase
    end

    // ----------------------------------------
    // ModR/M sub-op decode
    // ----------------------------------------
    wire logic [2:0] sub = b[`SUB_HI:`SUB_LO];
    wire logic [1:0] md = b[`MOD_HI:`MOD_LO];
    wire logic [1:0] disp_n = (md == `MOD_D8) ? 2'h1 : (md == `MOD_D16) ? 2'h2 :
        (md == `MOD_NONE && b[2:0] == `RM_DIRECT) ? 2'h2 : 2'h0;
    op_class_t op2;
    logic bad2;
    logic [2:0] imm2n;
    always_comb begin
        op2 = cur.op;
        bad2 = 1'b0;
        imm2n = 3'h0;
        if (cur.count_src != CNT_NONE) begin
            case (sub)
                3'h0: op2 = OP_ROTL;
                3'h1: op2 = OP_ROTR;
                3'h2: op2 = OP_RCL;
                3'h3: op2 = OP_RCR;
                3'h4: op2 = OP_SHL;
                3'h5: op2 = OP_SHR;
                3'h7: op2 = OP_SAR;
                default: bad2 = 1'b1;
            endcase
            imm2n = (cur.count_src == CNT_IMM) ? 3'h1 : 3'h0;
        end else if (cur.imm[8]) begin
            case (sub)
                3'h1: op2 = OP_OR;
                3'h4: op2 = OP_AND;
                3'h6: op2 = OP_XOR;
                default: op2 = OP_OTHER;
            endcase
            imm2n = cur.word ? 3'h2 : 3'h1;
        end else if (cur.imm[9]) begin
            case (sub)
                3'h0: op2 = OP_TEST;
                3'h2: op2 = OP_NOT;
                default: op2 = OP_OTHER;
            endcase
            imm2n = (sub == 3'h0) ? (cur.word ? 3'h2 : 3'h1) : 3'h0;
        end else if (cur.imm[10]) begin
            case (sub)
                3'h2: op2 = OP_CALL;
                3'h3: op2 = OP_CALLF;
                3'h4: op2 = OP_JMP;
                3'h5: op2 = OP_JMPF;
                default: op2 = OP_OTHER;
            endcase
            bad2 = md == `MOD_REG && (sub == 3'h3 || sub == 3'h5);
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    wire logic last_modrm = (disp_n == 2'h0) && (imm2n == 3'h0);
    wire logic last_byte =
        (state == ST_OPC && !is_prefix && b != `PFX_TWO_BYTE && !needs_modrm && fixed_imm == 3'h0)
        || (state == ST_MODRM && last_modrm) || (state == ST_DISP && disp_left == 2'h1 && imm_left == 3'h0)
        || (state == ST_IMM && imm_left == 3'h1) || state == ST_EXT;
    wire logic [3:0] imm_idx = {1'b0, imm_total - imm_left};

    always_comb begin
        next_state = state;
        case (state)
            ST_OPC: begin
                if (b == `PFX_TWO_BYTE) next_state = ST_EXT;
                else if (is_prefix) next_state = ST_OPC;
                else if (needs_modrm) next_state = ST_MODRM;
                else if (fixed_imm != 3'h0) next_state = ST_IMM;
            end
            ST_MODRM: next_state = (disp_n != 2'h0) ? ST_DISP : (imm2n != 3'h0) ? ST_IMM : ST_OPC;
            ST_DISP: next_state = (disp_left != 2'h1) ? ST_DISP : (imm_left != 3'h0) ? ST_IMM : ST_OPC;
            ST_IMM: next_state = (imm_left == 3'h1) ? ST_OPC : ST_IMM;
            ST_EXT: next_state = ST_OPC;
            default: next_state = ST_OPC;
        endcase
        if (last_byte) next_state = ST_OPC;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_OPC;
            cur <= '0;
            disp_left <= 2'h0;
            imm_left <= 3'h0;
            imm_total <= 3'h0;
            dec_out <= '0;
            dec_valid <= 1'b0;
            esc_valid <= 1'b0;
            fetch_ready <= 1'b0;
        end else begin
            fetch_ready <= 1'b1;
            dec_valid <= 1'b0;
            esc_valid <= 1'b0;
            if (take) begin
                state <= next_state;
                case (state)
                    ST_OPC: begin
                        if (b == `PFX_REP_Z || b == `PFX_REP_NZ) begin
                            cur.repeat_prefix <= 1'b1;
                            cur.rep_z <= b[0];
                        end else if (b == `PFX_LOCK) begin
                            cur.lock <= 1'b1;
                        end else begin
                            cur.op <= op1;
                            cur.word <= (is_jcc || b == 8'h62 || is_esc || is_ff) ? 1'b1 : w;
                            cur.dir <= b[1];
                            cur.cond <= b[3:0];
                            cur.count_src <= (b[7:1] == 7'h68) ? CNT_ONE : (b[7:1] == 7'h69) ? CNT_REG :
                                (b[7:1] == 7'h60) ? CNT_IMM : CNT_NONE;
                            cur.imm <= {5'h00, is_ff, is_grp3, is_grp1, (b == 8'hCC) ? `INT3_TYPE : 8'h00};
                            cur.imm2 <= '0;
                            cur.disp <= '0;
                            cur.has_modrm <= needs_modrm;
                            cur.invalid <= 1'b0;
                            imm_total <= fixed_imm;
                            imm_left <= fixed_imm;
                            // only compare and scan honour the zero sense
                            if (!(op1 == OP_SCMP || op1 == OP_SSCAN)) cur.rep_z <= 1'b1;
                        end
                    end
                    ST_MODRM: begin
                        cur.op <= op2;
                        cur.invalid <= bad2;
                        cur.imm <= '0;
                        cur.modf <= md;
                        cur.regf <= sub;
                        cur.rmf <= b[2:0];
                        cur.rm_is_reg <= (md == `MOD_REG);
                        disp_left <= disp_n;
                        imm_left <= imm2n;
                        imm_total <= imm2n;
                    end
                    ST_DISP: begin
                        disp_left <= disp_left - 2'h1;
                        if (cur.modf == `MOD_D8) cur.disp <= {{8{b[7]}}, b};
                        else if (disp_left == 2'h2) cur.disp[7:0] <= b;
                        else cur.disp[15:8] <= b;
                    end
                    ST_IMM: begin
                        imm_left <= imm_left - 3'h1;
                        case (imm_idx)
                            4'h0: cur.imm[7:0] <= b;
                            4'h1: cur.imm[15:8] <= b;
                            4'h2: cur.imm2[7:0] <= b;
                            default: cur.imm2[15:8] <= b;
                        endcase
                    end
                    default: cur <= cur;
                endcase
                if (last_byte) begin
                    dec_valid <= 1'b1;
                    cur.repeat_prefix <= 1'b0;
                    cur.lock <= 1'b0;
                    dec_out <= cur;
                    if (state == ST_OPC) begin
                        dec_out.op <= op1;
                        dec_out.word <= w;
                        dec_out.cond <= b[3:0];
                        dec_out.rep_z <= (op1 == OP_SCMP || op1 == OP_SSCAN) ? cur.rep_z : 1'b1;
                        dec_out.imm <= (b == 8'hCC) ? {8'h00, `INT3_TYPE} : 16'h0000;
                        dec_out.imm2 <= '0;
                        dec_out.disp <= '0;
                        dec_out.has_modrm <= 1'b0;
                        dec_out.count_src <= CNT_NONE;
                        dec_out.invalid <= 1'b0;
                    end else if (state == ST_MODRM) begin
                        dec_out.op <= op2;
                        dec_out.invalid <= bad2;
                        dec_out.modf <= md;
                        dec_out.regf <= sub;
                        dec_out.rmf <= b[2:0];
                        dec_out.rm_is_reg <= (md == `MOD_REG);
                        dec_out.imm <= '0;
                        esc_valid <= (cur.op == OP_ESC);
                    end else if (state == ST_DISP) begin
                        if (cur.modf == `MOD_D8) dec_out.disp <= {{8{b[7]}}, b};
                        else dec_out.disp[15:8] <= b;
                        esc_valid <= (cur.op == OP_ESC);
                    end else if (state == ST_IMM) begin
                        case (imm_idx)
                            4'h0: dec_out.imm[7:0] <= b;
                            4'h1: dec_out.imm[15:8] <= b;
                            4'h2: dec_out.imm2[7:0] <= b;
                            default: dec_out.imm2[15:8] <= b;
                        endcase
                    end else begin
                        dec_out.op <= (b == `OP_CLR_TS) ? OP_CLTS : OP_OTHER;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_halt_decode: assert property (take && state == ST_OPC && b == 8'hF4
        |=> dec_valid && dec_out.op == OP_HALT) else $error("halt byte not decoded");
    chk_carry_ops: assert property (take && state == ST_OPC && b == 8'hF8
        |=> dec_valid && dec_out.op == OP_CLC) else $error("clear carry not decoded");
    chk_jcc_disp: assert property (take && state == ST_OPC && b == 8'h74
        |=> !dec_valid && state == ST_IMM) else $error("conditional jump did not wait for displacement");
    chk_int3_type: assert property (take && state == ST_OPC && b == 8'hCC
        |=> dec_out.imm == 16'h0003) else $error("int3 type wrong");
    chk_shift_bad: assert property (take && state == ST_MODRM && cur.count_src == CNT_ONE && sub == 3'h6
        && md == `MOD_REG |=> dec_valid && dec_out.invalid) else $error("unassigned shift sub-op not flagged");
    chk_reg_operand: assert property (dec_valid && dec_out.has_modrm
        |-> dec_out.rm_is_reg == (dec_out.modf == `MOD_REG)) else $error("register operand flag mismatch");
    chk_far_mem: assert property (dec_valid && dec_out.op == OP_JMPF && dec_out.has_modrm
        && dec_out.rm_is_reg |-> dec_out.invalid) else $error("far indirect jump from register accepted");
    chk_disp_sign: assert property (dec_valid && dec_out.modf == `MOD_D8 && dec_out.has_modrm
        |-> dec_out.disp[15:8] == {8{dec_out.disp[7]}}) else $error("short displacement not sign-extended");
    chk_ret_imm: assert property (take && state == ST_OPC && b == 8'hC2
        |=> state == ST_IMM ##1 !dec_valid) else $error("return with adjust did not take immediate");
    cov_rep_scan: cover property (@(posedge sys_clk) dec_valid && dec_out.repeat_prefix && dec_out.op == OP_SSCAN);
    cov_esc: cover property (@(posedge sys_clk) esc_valid);
    cov_shift_imm: cover property (@(posedge sys_clk) dec_valid && dec_out.count_src == CNT_IMM);
endmodule : opcode_decoder

// >>> test/fetch_model.sv
// fetch unit model: hands queued instruction bytes to the decoder with random stalls
`timescale 1ns/1ps
module fetch_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // byte stream to the decoder
    input wire logic fetch_ready,
    output logic [7:0] fetch_byte,
    output logic fetch_valid
);
    logic [7:0] pend[$];
    integer seed = 9;
    initial begin
        fetch_byte = 8'h00;
        fetch_valid = 1'b0;
    end
    task automatic push(input logic [7:0] b);
        pend.push_back(b);
    endtask : push
    // an offered byte stands until taken; an idle line inverts every bit of fetch_byte on each cycle in reset or with fetch_ready high
    always @(posedge sys_clk) begin
        if (reset_n && fetch_ready && pend.size() > 0 && ($random(seed) & 3) != 0) begin
            fetch_byte <= pend.pop_front();
            fetch_valid <= 1'b1;
        end else if (!reset_n || fetch_ready) begin
            fetch_byte <= ~fetch_byte;
            fetch_valid <= 1'b0;
        end
    end
endmodule : fetch_model

// >>> test/opcode_decoder_tb.sv
// self-checking bench: decoder results against a queue of expected results
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module opcode_decoder_tb import opdec_pkg::*;;
    localparam int M_OP = 1, M_W = 2, M_CNT = 4, M_REP = 8, M_DISP = 16, M_IMM = 32;
    localparam int M_IMM2 = 64, M_COND = 128, M_REG = 256, M_LOCK = 512, M_IMM8 = 1024;
    logic sys_clk;
    logic reset_n = 1'b0;
    logic [7:0] fetch_byte, r, s;
    logic fetch_valid, fetch_ready, dec_valid, esc_valid, w;
    decoded_t dec_out, e, x;
    decoded_t exp_q[$];
    int mask_q[$];
    logic [7:0] bq[$];
    int failures = 0, checks_done = 0, seed = 9, m;
    op_class_t sh_op[8] = '{OP_ROTL, OP_ROTR, OP_RCL, OP_RCR, OP_SHL, OP_SHR, OP_NONE, OP_SAR};
    logic [7:0] sh_opc[3] = '{8'hD0, 8'hD2, 8'hC0};
    op_class_t lg_op[4] = '{OP_AND, OP_OR, OP_XOR, OP_TEST};
    logic [7:0] lg_reg[4] = '{8'h20, 8'h08, 8'h30, 8'h84};
    logic [7:0] lg_imm[4] = '{8'h80, 8'h80, 8'h80, 8'hF6};
    logic [7:0] lg_acc[4] = '{8'h24, 8'h00, 8'h34, 8'hA8};
    logic [2:0] lg_sub[4] = '{3'h4, 3'h1, 3'h6, 3'h0};
    logic [7:0] st_opc[7] = '{8'hA4, 8'hA6, 8'hAE, 8'hAC, 8'hAA, 8'h6C, 8'h6E};
    op_class_t st_op[7] = '{OP_SMOVE, OP_SCMP, OP_SSCAN, OP_SLOAD, OP_SSTORE, OP_SIN, OP_SOUT};
    logic [7:0] ct_opc[19] = '{8'hC3, 8'hCB, 8'hC9, 8'hCE, 8'hF8, 8'hF5, 8'hF9, 8'hF4, 8'hEB, 8'hE0,
        8'hE1, 8'hE2, 8'hE3, 8'hCD, 8'hE8, 8'hE9, 8'hC2, 8'hCA, 8'hC8};
    op_class_t ct_op[19] = '{OP_RET, OP_RETF, OP_LEAVE, OP_INTO, OP_CLC, OP_CMC, OP_STC, OP_HALT, OP_JMP,
        OP_LOOPNZ, OP_LOOPZ, OP_LOOP, OP_JUMP_COUNT_ZERO, OP_INT, OP_CALL, OP_JMP, OP_RET, OP_RETF, OP_ENTER};
    op_class_t ff_op[4] = '{OP_CALL, OP_CALLF, OP_JMP, OP_JMPF};

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    fetch_model fm (.sys_clk(sys_clk), .reset_n(reset_n), .fetch_ready(fetch_ready),
        .fetch_byte(fetch_byte), .fetch_valid(fetch_valid));
    opcode_decoder uut (.sys_clk(sys_clk), .reset_n(reset_n), .fetch_byte(fetch_byte),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .dec_out(dec_out),
        .dec_valid(dec_valid), .esc_valid(esc_valid));

    task automatic go(input logic [7:0] b[$], input int mk);
        foreach (b[i]) fm.push(b[i]);
        exp_q.push_back(e);
        mask_q.push_back(mk);
        e = '0;
    endtask : go

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // ----
    // scoreboard
    // ----
    always @(posedge sys_clk) begin
        if (reset_n && dec_valid) begin
            `CHK(exp_q.size() > 0, 1'b1)
            x = exp_q.pop_front();
            m = mask_q.pop_front();
            `CHK(dec_out.invalid, x.invalid)
            `CHK(esc_valid, x.op == OP_ESC)
            if (m & M_OP) `CHK(dec_out.op, x.op)
            if (m & M_W) `CHK(dec_out.word, x.word)
            if (m & M_CNT) `CHK(dec_out.count_src, x.count_src)
            if (m & M_REP) `CHK(dec_out.repeat_prefix, x.repeat_prefix)
            if ((m & M_REP) && x.repeat_prefix) `CHK(dec_out.rep_z, x.rep_z)
            if (m & M_DISP) `CHK(dec_out.disp, x.disp)
            if (m & M_IMM) `CHK(dec_out.imm, x.imm)
            if (m & M_IMM8) `CHK(dec_out.imm[7:0], x.imm[7:0])
            if (m & M_IMM2) `CHK(dec_out.imm2, x.imm2)
            if (m & M_COND) `CHK(dec_out.cond, x.cond)
            if (m & M_REG) `CHK(dec_out.rm_is_reg, x.rm_is_reg)
            if (m & M_LOCK) `CHK(dec_out.lock, x.lock)
        end
    end

    // ----
    // stimulus and expected results
    // ----
    initial begin
        e = '0;
        for (int t = 0; t < 8; t++) for (int f = 0; f < 3; f++) begin
            r = $random(seed);
            w = r[7];
            e.op = sh_op[t]; e.invalid = t == 6; e.word = w; e.rm_is_reg = 1'b1; e.imm = {8'h00, r};
            e.count_src = count_src_t'(f + 1);
            bq = '{sh_opc[f] | w, {2'b11, t[2:0], 3'b010}};
            if (f == 2) bq.push_back(r);
            go(bq, t == 6 ? 0 : M_OP | M_W | M_CNT | M_REG | (f == 2 ? M_IMM8 : 0));
        end
        e.op = OP_SHL; e.word = 1'b1; e.count_src = CNT_IMM; e.disp = 16'hFF80; e.imm = 16'h0005;
        go('{8'hC1, 8'h60, 8'h80, 8'h05}, M_OP | M_W | M_CNT | M_DISP | M_REG | M_IMM8);
        e.op = OP_SAR; e.count_src = CNT_REG; e.disp = 16'h1234;
        go('{8'hD3, 8'hB9, 8'h34, 8'h12}, M_OP | M_CNT | M_DISP | M_REG);
        e.op = OP_XOR; e.word = 1'b1; e.disp = 16'hFFF0;
        go('{8'h31, 8'h45, 8'hF0}, M_OP | M_W | M_DISP | M_REG);
        e.op = OP_AND; e.word = 1'b1; e.disp = 16'h5678; e.imm = 16'hABCD;
        go('{8'h81, 8'h26, 8'h78, 8'h56, 8'hCD, 8'hAB}, M_OP | M_W | M_DISP | M_IMM | M_REG);
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            s = $random(seed);
            w = s[6];
            e.op = i == 4 ? OP_NOT : lg_op[i]; e.word = w; e.rm_is_reg = 1'b1;
            go('{i == 4 ? 8'hF6 | w : lg_reg[i] | {i < 3 && s[7], w}, {2'b11, i == 4 ? 3'h2 : s[5:3], s[2:0]}},
                M_OP | M_W | M_REG);
            if (i == 4) break;
            e.op = lg_op[i]; e.word = w; e.rm_is_reg = 1'b1; e.imm = {s, r};
            bq = '{lg_imm[i] | w, {2'b11, lg_sub[i], s[2:0]}, r};
            if (w) bq.push_back(s);
            go(bq, M_OP | M_W | M_REG | (w ? M_IMM : M_IMM8));
            if (i == 1) continue;
            e.op = lg_op[i]; e.word = w; e.imm = {s, r};
            bq = '{lg_acc[i] | w, r};
            if (w) bq.push_back(s);
            go(bq, M_OP | M_W | (w ? M_IMM : M_IMM8));
        end
        for (int i = 0; i < 7; i++) for (int p = 0; p < 3; p++) if (p < 2 || i == 1 || i == 2) begin
            w = $random(seed);
            e.op = st_op[i]; e.word = w; e.repeat_prefix = p != 0; e.rep_z = p != 2;
            bq = '{st_opc[i] | w};
            if (p != 0) bq.push_front(p == 1 ? 8'hF3 : 8'hF2);
            go(bq, M_OP | M_W | M_REP);
        end
        for (int i = 0; i < 35; i++) begin
            r = $random(seed);
            s = $random(seed);
            e.imm = {s, r};
            if (i < 19) begin
                e.op = ct_op[i];
                bq = '{ct_opc[i]};
                if (i > 7) bq.push_back(r);
                if (i > 13) bq.push_back(s);
                go(bq, M_OP | (i > 13 ? M_IMM : i > 7 ? M_IMM8 : 0));
            end else begin
                e.op = OP_JCC; e.cond = i - 19;
                go('{{4'h7, e.cond}, r}, M_OP | M_COND | M_IMM8);
            end
        end
        for (int k = 2; k < 6; k++) for (int md = 0; md < 2; md++) begin
            e.op = ff_op[k - 2]; e.invalid = k[0] && md == 1; e.rm_is_reg = md == 1;
            go('{8'hFF, {md == 1 ? 2'b11 : 2'b00, k[2:0], 3'b111}}, (e.invalid ? 0 : M_OP) | M_REG);
        end
        e.op = OP_CALLF; e.imm = {s, r}; e.imm2 = {r, s};
        go('{8'h9A, r, s, s, r}, M_OP | M_IMM | M_IMM2);
        e.op = OP_JMPF; e.imm = {r, s}; e.imm2 = {s, r};
        go('{8'hEA, s, r, r, s}, M_OP | M_IMM | M_IMM2);
        e.op = OP_INT; e.imm = 16'h0003;
        go('{8'hCC}, M_OP | M_IMM8);
        e.op = OP_BOUND; e.rm_is_reg = 1'b1;
        go('{8'h62, 8'hC1}, M_OP | M_REG);
        e.op = OP_NOT; e.lock = 1'b1;
        go('{8'hF0, 8'hF6, 8'hD0}, M_OP | M_LOCK);
        e.op = OP_HALT;
        go('{8'hF4}, M_OP | M_LOCK);
        e.op = OP_CLTS;
        go('{8'h0F, 8'h06}, M_OP);
        for (int t = 0; t < 8; t++) begin
            r = $random(seed);
            e.op = OP_ESC;
            go('{{5'h1B, t[2:0]}, {2'b11, r[5:0]}}, M_OP);
        end
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int n = 0; n < 4000 && exp_q.size() > 0; n++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        if (exp_q.size() != 0) failures++;
        report_and_stop();
    end
endmodule : opcode_decoder_tb
